// ===== shared/portb_pkg.sv
// Purpose: Constants for the port-B bus matching and byte swapping block
// Assumes: Size and swap selects are coded {hi, lo}
// Notes:   Long word is four 9-bit byte lanes, lane 3 on the top bits
//
// Behaviour
// RL1: Long writes stored through selected swap mode
// RL2: Long reads driven through selected swap mode
// RL3: Two word writes assemble, then swap
// RL4: Four byte writes assemble, then swap
// RL5: Word reads swap first, two halves out
// RL6: Unused half holds last queue output value
// RL7: Byte reads swap first, four lanes out
// RL8: Both sizes high reads A-to-B mailbox
// RL9: Both sizes high writes B-to-A mailbox
// RL10: Parity flag checks only lanes in use
// RL11: Port A sees stored order unchanged
// RL12: Swap mode latched on first beat
// RL13: Controller selects long size with zeros
// RL14: Partials gather; last beat stores word
// RL15: Selects sampled on every transfer edge
package portb_pkg;

   localparam int DATA_W = 36;
   localparam int HALF_W = 18;
   localparam int BYTE_W = 9;
   localparam int LANES  = 4;

   // Bus size codes {size_sel_hi, size_sel_lo}
   localparam logic [1:0] SIZE_LONG = 2'h0;
   localparam logic [1:0] SIZE_BYTE = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] SIZE_MAIL = 2'h3;

   // Swap mode codes {swap_sel_hi, swap_sel_lo}
   localparam logic [1:0] SWAP_NONE  = 2'h0;
   localparam logic [1:0] SWAP_REV   = 2'h1;
   localparam logic [1:0] SWAP_HALF  = 2'h2;
   localparam logic [1:0] SWAP_INNER = 2'h3;

   // Beat counts
   localparam logic [1:0] BEAT_FIRST = 2'h0;
   localparam logic [1:0] WORD_LAST  = 2'h1;
   localparam logic [1:0] BYTE_LAST  = 2'h3;

   // Parity lane masks, bit 3 is the top lane
   localparam logic [3:0] LANES_ALL     = 4'hf;
   localparam logic [3:0] LANES_WORD_BE = 4'hc;
   localparam logic [3:0] LANES_WORD_LE = 4'h3;
   localparam logic [3:0] LANES_BYTE_BE = 4'h8;
   localparam logic [3:0] LANES_BYTE_LE = 4'h1;

   // Reset values
   localparam logic [35:0] DATA_RST = 36'h0;

endpackage

// ===== verilog/byte_swap.sv
// Purpose: Byte-order permutation of one long word
// Assumes: Four lanes of BW bits each
// Notes:   Bit order inside a lane never changes
`timescale 1ns/10ps
`default_nettype none
module byte_swap
   import portb_pkg::*;
#(
   parameter int BW = 9
) (
   // Control
   input  wire logic [1:0]      mode,
   // Data
   input  wire logic [4*BW-1:0] din,
   output logic      [4*BW-1:0] dout
);
   logic [BW-1:0] l3, l2, l1, l0;

   assign l3 = din[4*BW-1:3*BW];
   assign l2 = din[3*BW-1:2*BW];
   assign l1 = din[2*BW-1:BW];
   assign l0 = din[BW-1:0];

   always_comb begin
      case (mode)
         SWAP_REV:   dout = {l0, l1, l2, l3};
         SWAP_HALF:  dout = {l1, l0, l3, l2};
         SWAP_INNER: dout = {l2, l3, l0, l1};
         default:    dout = {l3, l2, l1, l0};
      endcase
   end
endmodule
`default_nettype wire

// ===== verilog/lane_parity.sv
// Purpose: Per-lane parity check with a lane mask
// Assumes: odd_sel high selects odd parity
// Notes:   Masked-off lanes never report an error
`timescale 1ns/10ps
`default_nettype none
module lane_parity #(
   parameter int NL = 4,
   parameter int BW = 9
) (
   // Data and selection
   input  wire logic [NL*BW-1:0] data,
   input  wire logic [NL-1:0]    lane_mask,
   input  wire logic             odd_sel,
   // Result
   output logic                  err
);
   logic [NL-1:0] lane_bad;

   for (genvar i = 0; i < NL; i++) begin : g_lane
      assign lane_bad[i] = lane_mask[i] & ((^data[i*BW +: BW]) != odd_sel);
   end

   assign err = |lane_bad;
endmodule
`default_nettype wire

// ===== verilog/portb_bus_match_byte_swap.sv
// Purpose: Port-B bus matching, byte swapping and mailbox steering
// Assumes: Port-B controller is synchronous logic on sys_clk
// Notes:   Queue storage, flags and port A live outside this block
`timescale 1ns/10ps
`default_nettype none
module portb_bus_match_byte_swap
   import portb_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   // Port-B controls
   input  wire logic              b_en,
   input  wire logic              b_wr_sel,
   input  wire logic              size_sel_hi,
   input  wire logic              size_sel_lo,
   input  wire logic              endian_sel,
   input  wire logic              swap_sel_hi,
   input  wire logic              swap_sel_lo,
   input  wire logic              odd_sel,
   // Port-B data
   input  wire logic [DATA_W-1:0] b_din,
   output logic      [DATA_W-1:0] b_dout,
   output logic                   portb_parity_err_n,
   // B-to-A queue write side
   output logic      [DATA_W-1:0] ba_wr_data,
   output logic                   ba_wr_valid,
   // A-to-B queue read side
   input  wire logic [DATA_W-1:0] ab_rd_data,
   output logic                   ab_rd_take,
   // Mailboxes
   input  wire logic [DATA_W-1:0] ab_mailbox_data,
   output logic      [DATA_W-1:0] ba_mailbox_data,
   output logic                   ba_mailbox_wr
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   logic [1:0]        size_code;
   logic [1:0]        swap_code;
   logic              mail_sel;
   logic              fifo_wr;
   logic              fifo_rd;

   logic [1:0]        wr_size_reg;
   logic [1:0]        wr_beat_reg;
   logic [1:0]        wr_swap_reg;
   logic [1:0]        wr_beat_eff;
   logic [1:0]        wr_mode;
   logic              wr_last;
   logic [DATA_W-1:0] aux_reg;
   logic [DATA_W-1:0] asm_word;
   logic [DATA_W-1:0] wr_swapped;

   logic [1:0]        rd_size_reg;
   logic [1:0]        rd_beat_reg;
   logic [1:0]        rd_beat_eff;
   logic [1:0]        be_lane;
   logic              rd_last;
   logic [DATA_W-1:0] rd_swapped;
   logic [DATA_W-1:0] rd_hold_reg;
   logic [DATA_W-1:0] rd_out_reg;
   logic [DATA_W-1:0] rd_word;
   logic [DATA_W-1:0] dout_next;

   logic [LANES-1:0]  par_mask;
   logic              par_err;

   // Transfer decode
   assign size_code = {size_sel_hi, size_sel_lo};
   assign swap_code = {swap_sel_hi, swap_sel_lo};
   assign mail_sel  = (size_code == SIZE_MAIL);      // [RL8] [RL9]
   assign fifo_wr   = b_en & b_wr_sel & ~mail_sel;
   assign fifo_rd   = b_en & ~b_wr_sel & ~mail_sel;

   // ---------------- Write path into the B-to-A queue ----------------
   // A new size restarts assembly; pending partials are dropped
   assign wr_beat_eff = (size_code == wr_size_reg) ? wr_beat_reg : BEAT_FIRST;
   assign wr_mode     = (wr_beat_eff == BEAT_FIRST) ? swap_code : wr_swap_reg; // [RL12]

   always_comb begin
      case (size_code)
         SIZE_WORD: begin
            // Big endian shifts upper half in low; little endian in high [RL3]
            if (endian_sel) begin
               asm_word = {aux_reg[HALF_W-1:0], b_din[DATA_W-1:HALF_W]};
            end else begin
               asm_word = {b_din[HALF_W-1:0], aux_reg[DATA_W-1:HALF_W]};
            end
            wr_last = (wr_beat_eff == WORD_LAST);
         end
         SIZE_BYTE: begin
            // Top lane most significant first, bottom lane least first [RL4]
            if (endian_sel) begin
               asm_word = {aux_reg[DATA_W-BYTE_W-1:0], b_din[DATA_W-1:DATA_W-BYTE_W]};
            end else begin
               asm_word = {b_din[BYTE_W-1:0], aux_reg[DATA_W-1:BYTE_W]};
            end
            wr_last = (wr_beat_eff == BYTE_LAST);
         end
         default: begin
            asm_word = b_din;
            wr_last  = 1'b1;
         end
      endcase
   end

   // Swap after assembly [RL1] [RL3] [RL4]
   byte_swap #(
      .BW   (BYTE_W)
   ) u_wr_swap (
      .mode (wr_mode),
      .din  (asm_word),
      .dout (wr_swapped)
   );

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_size_reg <= SIZE_LONG;
         wr_beat_reg <= BEAT_FIRST;
         wr_swap_reg <= SWAP_NONE;
      end else if (fifo_wr) begin
         wr_size_reg <= size_code;                                  // [RL15]
         wr_beat_reg <= wr_last ? BEAT_FIRST : wr_beat_eff + 2'h1;
         if (wr_beat_eff == BEAT_FIRST) begin
            wr_swap_reg <= swap_code;                               // [RL12]
         end
      end
   end

   // Partials gather in the auxiliary register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         aux_reg <= DATA_RST;
      end else if (fifo_wr && !wr_last) begin
         aux_reg <= asm_word;                                       // [RL14]
      end
   end

   // Final beat stores the long word in final order; port A reads it as is
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ba_wr_valid <= 1'b0;
         ba_wr_data  <= DATA_RST;
      end else begin
         ba_wr_valid <= fifo_wr & wr_last;                          // [RL14]
         if (fifo_wr && wr_last) begin
            ba_wr_data <= wr_swapped;                               // [RL11]
         end
      end
   end

   // Mailbox write bypasses assembly and leaves its state alone
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ba_mailbox_wr   <= 1'b0;
         ba_mailbox_data <= DATA_RST;
      end else begin
         ba_mailbox_wr <= b_en & b_wr_sel & mail_sel;               // [RL9]
         if (b_en && b_wr_sel && mail_sel) begin
            ba_mailbox_data <= b_din;                               // [RL9]
         end
      end
   end

   // ---------------- Read path from the A-to-B queue ----------------
   assign rd_beat_eff = (size_code == rd_size_reg) ? rd_beat_reg : BEAT_FIRST;
   assign ab_rd_take  = fifo_rd & (rd_beat_eff == BEAT_FIRST);      // [RL15]
   assign be_lane     = ~rd_beat_eff;

   // Swap mode only matters on the first beat; later beats use the hold
   byte_swap #(
      .BW   (BYTE_W)
   ) u_rd_swap (
      .mode (swap_code),
      .din  (ab_rd_data),
      .dout (rd_swapped)
   );

   assign rd_word = (rd_beat_eff == BEAT_FIRST) ? rd_swapped : rd_hold_reg; // [RL12]

   // Lanes not written keep the last queue output value [RL6] [RL7]
   always_comb begin
      dout_next = rd_out_reg;
      rd_last   = 1'b1;
      case (size_code)
         SIZE_WORD: begin
            rd_last = (rd_beat_eff == WORD_LAST);
            if (endian_sel) begin
               dout_next[DATA_W-1:HALF_W] = rd_beat_eff[0] ? rd_word[HALF_W-1:0]
                                                           : rd_word[DATA_W-1:HALF_W]; // [RL5]
            end else begin
               dout_next[HALF_W-1:0] = rd_beat_eff[0] ? rd_word[DATA_W-1:HALF_W]
                                                      : rd_word[HALF_W-1:0];           // [RL5]
            end
         end
         SIZE_BYTE: begin
            rd_last = (rd_beat_eff == BYTE_LAST);
            if (endian_sel) begin
               dout_next[DATA_W-1:DATA_W-BYTE_W] = rd_word[BYTE_W*be_lane +: BYTE_W];  // [RL7]
            end else begin
               dout_next[BYTE_W-1:0] = rd_word[BYTE_W*rd_beat_eff +: BYTE_W];          // [RL7]
            end
         end
         default: begin
            dout_next = rd_word;                                    // [RL2]
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_size_reg <= SIZE_LONG;
         rd_beat_reg <= BEAT_FIRST;
      end else if (fifo_rd) begin
         rd_size_reg <= size_code;                                  // [RL15]
         rd_beat_reg <= rd_last ? BEAT_FIRST : rd_beat_eff + 2'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_hold_reg <= DATA_RST;
      end else if (ab_rd_take) begin
         rd_hold_reg <= rd_swapped;                                 // [RL5] [RL7]
      end
   end

   // Mailbox read wins the bus; queue output register and sequencing untouched
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         b_dout     <= DATA_RST;
         rd_out_reg <= DATA_RST;
      end else if (b_en && !b_wr_sel && mail_sel) begin
         b_dout <= ab_mailbox_data;                                 // [RL8]
      end else if (fifo_rd) begin
         b_dout     <= dout_next;
         rd_out_reg <= dout_next;                                   // [RL6]
      end
   end

   // ---------------- Parity check of incoming lanes ----------------
   always_comb begin
      case (size_code)
         SIZE_WORD: par_mask = endian_sel ? LANES_WORD_BE : LANES_WORD_LE; // [RL10]
         SIZE_BYTE: par_mask = endian_sel ? LANES_BYTE_BE : LANES_BYTE_LE;
         default:   par_mask = LANES_ALL;
      endcase
   end

   lane_parity #(
      .NL        (LANES),
      .BW        (BYTE_W)
   ) u_par (
      .data      (b_din),
      .lane_mask (par_mask),
      .odd_sel   (odd_sel),
      .err       (par_err)
   );

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         portb_parity_err_n <= 1'b1;
      end else begin
         portb_parity_err_n <= ~(b_en & b_wr_sel & par_err);        // [RL10]
      end
   end

   // ---------------- Assertions ----------------
   sequence s_word_be_first;
      fifo_wr && size_code == SIZE_WORD && endian_sel && wr_beat_eff == BEAT_FIRST
         && swap_code == SWAP_REV;
   endsequence

   sequence s_word_be_next;
      fifo_wr && size_code == SIZE_WORD && endian_sel;
   endsequence

   sequence s_byte_le_first;
      fifo_wr && size_code == SIZE_BYTE && !endian_sel && wr_beat_eff == BEAT_FIRST
         && swap_code == SWAP_NONE;
   endsequence

   sequence s_byte_le_next;
      fifo_wr && size_code == SIZE_BYTE && !endian_sel;
   endsequence

   a_long_wr_rev: assert property ( // [RL1]
      fifo_wr && size_code == SIZE_LONG && swap_code == SWAP_REV |=> ba_wr_valid
         && ba_wr_data == {$past(b_din[8:0]), $past(b_din[17:9]),
                           $past(b_din[26:18]), $past(b_din[35:27])})
      else $error("long write reversal wrong");

   a_word_wr_pair: assert property ( // [RL3]
      s_word_be_first ##1 s_word_be_next |=> ba_wr_valid
         && ba_wr_data == {$past(b_din[26:18]), $past(b_din[35:27]),
                           $past(b_din[26:18], 2), $past(b_din[35:27], 2)})
      else $error("word pair assembly or latched swap wrong");

   a_byte_wr_four: assert property ( // [RL4]
      s_byte_le_first ##1 s_byte_le_next [*3] |=> ba_wr_valid
         && ba_wr_data == {$past(b_din[8:0]), $past(b_din[8:0], 2),
                           $past(b_din[8:0], 3), $past(b_din[8:0], 4)})
      else $error("byte assembly wrong");

   a_byte_wr_partial: assert property ( // [RL14]
      s_byte_le_first |=> !ba_wr_valid)
      else $error("partial byte stored early");

   a_long_rd_rev: assert property ( // [RL2]
      fifo_rd && size_code == SIZE_LONG && swap_code == SWAP_REV |=>
         b_dout == {$past(ab_rd_data[8:0]), $past(ab_rd_data[17:9]),
                    $past(ab_rd_data[26:18]), $past(ab_rd_data[35:27])})
      else $error("long read reversal wrong");

   a_word_rd_hold: assert property ( // [RL6]
      fifo_rd && size_code == SIZE_WORD && endian_sel |=>
         b_dout[HALF_W-1:0] == $past(rd_out_reg[HALF_W-1:0]))
      else $error("unused half changed on word read");

   a_byte_rd_hold: assert property ( // [RL7]
      fifo_rd && size_code == SIZE_BYTE && !endian_sel |=>
         b_dout[DATA_W-1:BYTE_W] == $past(rd_out_reg[DATA_W-1:BYTE_W]))
      else $error("unused lanes changed on byte read");

   a_mail_rd_out: assert property ( // [RL8]
      b_en && !b_wr_sel && mail_sel |-> !ab_rd_take ##1 b_dout == $past(ab_mailbox_data))
      else $error("mailbox read wrong");

   a_mail_wr_store: assert property ( // [RL9]
      b_en && b_wr_sel && mail_sel |=> ba_mailbox_wr && !ba_wr_valid
         && ba_mailbox_data == $past(b_din))
      else $error("mailbox write wrong");

   a_parity_word_be: assert property ( // [RL10]
      b_en && b_wr_sel && size_code == SIZE_WORD && endian_sel
         && (^b_din[35:27]) == odd_sel && (^b_din[26:18]) == odd_sel |=> portb_parity_err_n)
      else $error("parity flag looked at unused lanes");
endmodule
`default_nettype wire

// ===== dv/ab_queue_model.sv
// Purpose: A-to-B queue head model feeding the read side
// Assumes: Head word is always valid; pops on the edge with ab_rd_take
// Notes:   Each pop brings a fresh random word
`timescale 1ns/10ps
`default_nettype none
module ab_queue_model (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Queue head
   input  wire logic        ab_rd_take,
   output logic      [35:0] ab_rd_data
);
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ab_rd_data <= 36'h1a2b3c4d5;
      end else if (ab_rd_take) begin
         ab_rd_data <= 36'({$urandom(), $urandom()});
      end
   end
endmodule
`default_nettype wire

// ===== dv/portb_bus_match_byte_swap_tb.sv
// Purpose: Self-checking bench for port-B bus matching and swapping
// Assumes: Inputs change on the falling edge; outputs sampled one cycle later
// Notes:   Random beats from a fixed seed, with corner cases among them
`timescale 1ns/10ps
`default_nettype none
module portb_bus_match_byte_swap_tb;
   import portb_pkg::*;
   logic        sys_clk, rst_n, b_en, b_wr_sel, size_sel_hi, size_sel_lo;
   logic        endian_sel, swap_sel_hi, swap_sel_lo, odd_sel;
   logic        ba_wr_valid, ab_rd_take, ba_mailbox_wr, portb_parity_err_n;
   logic [35:0] b_din, b_dout, ba_wr_data, ab_rd_data, ab_mailbox_data, ba_mailbox_data;
   logic [35:0] head_seen, exp_out;
   logic        take_seen;
   int          n_fail, n_checks;

   portb_bus_match_byte_swap dut (.sys_clk(sys_clk), .rst_n(rst_n), .b_en(b_en), .b_wr_sel(b_wr_sel),
      .size_sel_hi(size_sel_hi), .size_sel_lo(size_sel_lo), .endian_sel(endian_sel),
      .swap_sel_hi(swap_sel_hi), .swap_sel_lo(swap_sel_lo), .odd_sel(odd_sel), .b_din(b_din),
      .b_dout(b_dout), .portb_parity_err_n(portb_parity_err_n), .ba_wr_data(ba_wr_data),
      .ba_wr_valid(ba_wr_valid), .ab_rd_data(ab_rd_data), .ab_rd_take(ab_rd_take),
      .ab_mailbox_data(ab_mailbox_data), .ba_mailbox_data(ba_mailbox_data), .ba_mailbox_wr(ba_mailbox_wr));
   ab_queue_model partner (.sys_clk(sys_clk), .rst_n(rst_n), .ab_rd_take(ab_rd_take), .ab_rd_data(ab_rd_data));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   function automatic logic [35:0] rnd36();
      return 36'({$urandom(), $urandom()});
   endfunction

   function automatic logic [35:0] swp(input logic [1:0] m, input logic [35:0] d);
      case (m)
         SWAP_REV:   return {d[8:0], d[17:9], d[26:18], d[35:27]};
         SWAP_HALF:  return {d[17:0], d[35:18]};
         SWAP_INNER: return {d[26:18], d[35:27], d[8:0], d[17:9]};
         default:    return d;
      endcase
   endfunction

   // Flag level expected for a write beat, only lanes in use count
   function automatic logic par_ok(input logic [35:0] d, input logic [1:0] sz, input logic en, input logic odd);
      logic [3:0] m;
      logic       bad;
      m = (sz == SIZE_WORD) ? (en ? 4'hc : 4'h3) : (sz == SIZE_BYTE) ? (en ? 4'h8 : 4'h1) : 4'hf;
      bad = 1'b0;
      for (int i = 0; i < 4; i++) bad |= m[i] & ((^d[i*9 +: 9]) ^ odd);
      return ~bad;
   endfunction

   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict;
      if (n_fail == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic do_reset(input int cyc);
      rst_n = 1'b0;
      b_en = 1'b0;
      repeat (cyc) @(negedge sys_clk);
      check(b_dout, 36'h0);
      check(ba_wr_valid, 1'b0);
      check(ba_mailbox_data, 36'h0);
      check(portb_parity_err_n, 1'b1);
      rst_n = 1'b1;
      exp_out = 36'h0;
   endtask

   task automatic idle;
      b_en = 1'b0;
      @(negedge sys_clk);
   endtask

   // One beat; leaves b_en high so beats run back to back
   task automatic beat(input logic wr, input logic [1:0] sz, input logic en, input logic [1:0] sw,
                       input logic [35:0] d);
      logic        odd;
      logic [35:0] mb;
      odd = 1'($urandom());
      mb = rnd36();
      b_en = 1'b1;
      b_wr_sel = wr;
      {size_sel_hi, size_sel_lo} = sz;
      endian_sel = en;
      {swap_sel_hi, swap_sel_lo} = sw;
      odd_sel = odd;
      b_din = d;
      ab_mailbox_data = mb;
      #1;
      take_seen = ab_rd_take;
      head_seen = ab_rd_data;
      @(negedge sys_clk);
      check(portb_parity_err_n, wr ? par_ok(d, sz, en, odd) : 1'b1);
      check(ba_mailbox_wr, wr && sz == SIZE_MAIL);
      if (sz == SIZE_MAIL) begin
         if (wr) check(ba_mailbox_data, d);
         else check(b_dout, mb);
         check(take_seen, 1'b0);
      end
   endtask

   task automatic wr_op(input logic [1:0] sz, input logic en, input logic [1:0] sw, input bit mid);
      logic [35:0] acc, d;
      int          n, w;
      n = (sz == SIZE_WORD) ? 2 : (sz == SIZE_BYTE) ? 4 : 1;
      w = 36 / n;
      acc = 36'h0;
      for (int k = 0; k < n; k++) begin
         d = rnd36();
         acc = en ? ((acc << w) | (d >> (36 - w))) : ((acc >> w) | (d << (36 - w)));
         beat(1'b1, sz, en, (k == 0) ? sw : 2'($urandom()), d);
         check(ba_wr_valid, k == n - 1);
         if (mid && k == 0 && n > 1) beat(1'b1, SIZE_MAIL, en, sw, rnd36());
      end
      check(ba_wr_data, swp(sw, acc));
   endtask

   task automatic rd_op(input logic [1:0] sz, input logic en, input logic [1:0] sw);
      logic [35:0] s, m;
      int          n, w;
      n = (sz == SIZE_WORD) ? 2 : (sz == SIZE_BYTE) ? 4 : 1;
      w = 36 / n;
      m = en ? (~36'h0 << (36 - w)) : ~(~36'h0 << w);
      for (int k = 0; k < n; k++) begin
         beat(1'b0, sz, en, (k == 0) ? sw : 2'($urandom()), rnd36());
         if (k == 0) s = swp(sw, head_seen);
         check(take_seen, k == 0);
         exp_out = (exp_out & ~m) | ((en ? (s << (w * k)) : (s >> (w * k))) & m);
         check(b_dout, exp_out);
      end
   endtask

   initial begin
      logic [1:0] sizes [3];
      sizes = '{SIZE_LONG, SIZE_WORD, SIZE_BYTE};
      b_wr_sel = 1'b0;
      {size_sel_hi, size_sel_lo} = SIZE_LONG;
      endian_sel = 1'b0;
      {swap_sel_hi, swap_sel_lo} = SWAP_NONE;
      odd_sel = 1'b0;
      b_din = 36'h0;
      ab_mailbox_data = 36'h0;
      n_fail = 0;
      n_checks = 0;
      void'($urandom(12));
      do_reset(16);
      // Partial word dropped by a size change
      beat(1'b1, SIZE_WORD, 1'b1, SWAP_NONE, rnd36());
      check(ba_wr_valid, 1'b0);
      wr_op(SIZE_LONG, 1'b0, SWAP_REV, 1'b0);
      // Back-to-back beats with no mailbox in between
      wr_op(SIZE_WORD, 1'b1, SWAP_REV, 1'b0);
      wr_op(SIZE_BYTE, 1'b0, SWAP_NONE, 1'b0);
      for (int i = 0; i < 8; i++) begin
         for (int j = 0; j < 3; j++) wr_op(sizes[j], i[2], i[1:0], 1'b1);
      end
      repeat (30) wr_op(sizes[$urandom() % 3], 1'($urandom()), 2'($urandom()), ($urandom() % 3) == 0);
      do_reset(3);
      for (int i = 0; i < 8; i++) begin
         for (int j = 0; j < 3; j++) rd_op(sizes[j], i[2], i[1:0]);
      end
      repeat (30) begin
         if ($urandom() % 4 == 0) begin
            beat(1'b0, SIZE_MAIL, 1'($urandom()), 2'($urandom()), rnd36());
            rd_op(SIZE_LONG, 1'($urandom()), 2'($urandom()));
            // Unused lanes show queue data, not the mailbox just read
            beat(1'b0, SIZE_MAIL, 1'($urandom()), 2'($urandom()), rnd36());
            rd_op(sizes[1 + $urandom() % 2], 1'($urandom()), 2'($urandom()));
         end else begin
            rd_op(sizes[$urandom() % 3], 1'($urandom()), 2'($urandom()));
         end
      end
      idle;
      print_verdict;
   end

   initial begin
      #100000;
      n_fail++;
      print_verdict;
   end
endmodule
`default_nettype wire
